// >>> src/xarf_pkg.sv
`default_nettype none
package xarf_pkg;
   localparam int XARF_GPR_W = 32;
   localparam int XARF_SEG_W = 16;
   localparam int XARF_FP_W = 80;
   localparam int XARF_MM_W = 64;
   localparam int XARF_NUM_GPR = 8;
   localparam int XARF_NUM_SEG = 6;
   localparam int XARF_NUM_FP = 8;
   // general-purpose register numbers
   localparam logic [2:0] XARF_GPR_ACCUM = 3'h0;
   localparam logic [2:0] XARF_GPR_COUNTER = 3'h1;
   localparam logic [2:0] XARF_GPR_PORT = 3'h2;
   localparam logic [2:0] XARF_GPR_POINTER = 3'h3;
   localparam logic [2:0] XARF_GPR_STACK_TOP = 3'h4;
   localparam logic [2:0] XARF_GPR_FRAME_BASE = 3'h5;
   localparam logic [2:0] XARF_GPR_SOURCE_INDEX = 3'h6;
   localparam logic [2:0] XARF_GPR_DEST_INDEX = 3'h7;
   // segment register numbers
   localparam logic [2:0] XARF_SEG_DATA_TWO = 3'h0;
   localparam logic [2:0] XARF_SEG_CODE = 3'h1;
   localparam logic [2:0] XARF_SEG_STACK = 3'h2;
   localparam logic [2:0] XARF_SEG_DATA_ONE = 3'h3;
   localparam logic [2:0] XARF_SEG_DATA_THREE = 3'h4;
   localparam logic [2:0] XARF_SEG_DATA_FOUR = 3'h5;
   // reset values
   localparam logic [31:0] XARF_GPR_RST = 32'h0000_0000;
   localparam logic [15:0] XARF_SEG_RST = 16'h0000;
   localparam logic [31:0] XARF_IP_RST = 32'h0000_0000;
   localparam logic [79:0] XARF_FP_RST = 80'h0;
   localparam logic [15:0] XARF_FSW_RST = 16'h0000;
   localparam logic [15:0] XARF_FCW_RST = 16'h0000;
   localparam logic [15:0] XARF_FTW_RST = 16'h0000;
   // real-mode base = selector shifted left by this many bits
   localparam int XARF_REAL_SHIFT = 4;
   // protected mode: selector bits 15:3 index the descriptor table
   localparam int XARF_SEL_IDX_LSB = 3;
   // multimedia view: low bits of the shared float entry; upper bits forced to ones
   localparam logic [15:0] XARF_MM_EXP_FILL = 16'hffff;

   typedef enum logic [1:0] {
      XARF_SZ_BYTE_LO = 2'b00,
      XARF_SZ_BYTE_HI = 2'b01,
      XARF_SZ_WORD = 2'b10,
      XARF_SZ_DWORD = 2'b11
   } xarf_size_t;

   typedef enum logic [1:0] {
      XARF_FPW_FULL = 2'b00,
      XARF_FPW_MM = 2'b01,
      XARF_FPW_NONE = 2'b10
   } xarf_fpw_t;

   typedef enum logic [1:0] {
      XARF_IP_HOLD = 2'b00,
      XARF_IP_STEP = 2'b01,
      XARF_IP_XFER = 2'b10
   } xarf_ipop_t;

   // merge new data into an old value through a size-selected name
   function automatic logic [31:0] xarf_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input xarf_size_t sz);
      logic [31:0] r;
      r = old_v;
      unique case (sz)
         XARF_SZ_BYTE_LO: r[7:0] = new_v[7:0];
         XARF_SZ_BYTE_HI: r[15:8] = new_v[7:0];
         XARF_SZ_WORD: r[15:0] = new_v[15:0];
         XARF_SZ_DWORD: r = new_v;
      endcase
      return r;
   endfunction

   // extract a size-selected name, zero-extended
   function automatic logic [31:0] xarf_view(input logic [31:0] v, input xarf_size_t sz);
      logic [31:0] r;
      r = 32'h0;
      unique case (sz)
         XARF_SZ_BYTE_LO: r[7:0] = v[7:0];
         XARF_SZ_BYTE_HI: r[7:0] = v[15:8];
         XARF_SZ_WORD: r[15:0] = v[15:0];
         XARF_SZ_DWORD: r = v;
      endcase
      return r;
   endfunction
endpackage : xarf_pkg
`default_nettype wire

// >>> src/xarf_gpr_if.sv
`default_nettype none
interface xarf_gpr_if;
   import xarf_pkg::*;
   logic [XARF_NUM_GPR*XARF_GPR_W-1:0] regs_flat;
   logic wr_en;
   logic [2:0] wr_idx;
   logic [31:0] wr_data;
   xarf_size_t wr_size;
   logic wr_hit;
   modport owner (output regs_flat, input wr_en, input wr_idx, input wr_data, input wr_size,
      output wr_hit);
   modport user (input regs_flat, output wr_en, output wr_idx, output wr_data, output wr_size,
      input wr_hit);
endinterface : xarf_gpr_if
`default_nettype wire

// >>> src/xarf_gpr_bank.sv
`default_nettype none
module xarf_gpr_bank
   import xarf_pkg::*;
(
   input wire logic i_clock, // core clock
   input wire logic i_arst_n, // async reset
   xarf_gpr_if.owner bus // write side and flat view
);
   typedef struct packed {
      logic [XARF_NUM_GPR-1:0][XARF_GPR_W-1:0] gpr;
      logic hit;
   } xarf_gpr_state_t;

   xarf_gpr_state_t st_r;
   xarf_gpr_state_t st_nxt;

   always_comb begin
      st_nxt = st_r;
      st_nxt.hit = 1'b0;
      if (bus.wr_en) begin
         // byte names, high or low, exist only for the first four registers
         if (!bus.wr_size[1] && bus.wr_idx > XARF_GPR_POINTER) begin
            st_nxt.hit = 1'b0; // [RULE4]
         end else begin
            st_nxt.gpr[bus.wr_idx] = xarf_merge(st_r.gpr[bus.wr_idx], bus.wr_data,
               bus.wr_size); // [RULE2] [RULE3] [RULE5]
            st_nxt.hit = 1'b1;
         end
      end
   end

   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         st_r <= '{gpr: {XARF_NUM_GPR{XARF_GPR_RST}}, hit: 1'b0}; // [RULE20]
      end else begin
         st_r <= st_nxt;
      end
   end

   assign bus.regs_flat = st_r.gpr; // [RULE1]
   assign bus.wr_hit = st_r.hit;
endmodule : xarf_gpr_bank
`default_nettype wire

// >>> src/xarf_regfile.sv
// Summary of operation
// RULE1: eight 32-bit general-purpose registers
// RULE2: 16-bit name selects bits 15..0
// RULE3: first four registers have upper/lower byte names
// RULE4: index registers have word form, no bytes; only writes refuse bytes, byte reads of them are still served
// RULE5: narrow names alias storage, others bits kept
// RULE6: byte, word, dword, quadword operand access; a pair write stores only the low dword
// RULE7: six 16-bit segment registers
// RULE8: code, stack and four data segments
// RULE9: real mode: selector forms base directly
// RULE10: protected mode: selector picks a descriptor
// RULE11: fetch pointer, 32 or 16 bits wide
// RULE12: fetch pointer changes only by steps and transfers
// RULE13: eight 80-bit float stack entries
// RULE14: 16-bit float status word
// RULE15: float control word written by software
// RULE16: tag word tracks each stack entry
// RULE17: float entries hold all four formats
// RULE18: software leaves reserved areas untouched
// RULE19: 64-bit multimedia view shares float storage
// RULE20: everything resets to zero
`default_nettype none
module xarf_regfile
   import xarf_pkg::*;
(
   input wire logic i_clock, // core clock, 125 MHz
   input wire logic i_arst_n, // async reset, active low
   input wire logic i_gpr_wr_en, // integer write strobe
   input wire logic [2:0] i_gpr_wr_idx, // integer register number
   input wire xarf_size_t i_gpr_wr_size, // name width of write
   input wire logic [31:0] i_gpr_wr_data, // write data, low aligned
   input wire logic i_gpr_wr_quad, // pair write: forces a dword write of idx only
   input wire logic [31:0] i_gpr_wr_data_hi, // upper half for pair write; ignored, never stored
   input wire logic [2:0] i_gpr_rd_idx, // integer read register
   input wire xarf_size_t i_gpr_rd_size, // integer read width
   input wire logic i_seg_wr_en, // segment write strobe
   input wire logic [2:0] i_seg_wr_idx, // segment number
   input wire logic [15:0] i_seg_wr_data, // segment value
   input wire logic [2:0] i_seg_rd_idx, // segment for address base
   input wire logic i_prot_mode, // 1: protected addressing
   input wire logic i_op32, // 1: 32-bit fetch pointer
   input wire xarf_ipop_t i_ip_op, // fetch pointer update kind
   input wire logic [31:0] i_ip_value, // step length or transfer target
   input wire logic [2:0] i_fp_idx, // float entry number
   input wire xarf_fpw_t i_fp_wr, // float write kind
   input wire logic [79:0] i_fp_wr_data, // float or multimedia data
   input wire logic i_fsw_wr_en, // status word update
   input wire logic [15:0] i_fsw_wr_data, // status value
   input wire logic i_fcw_wr_en, // control word write
   input wire logic [15:0] i_fcw_wr_data, // control value
   input wire logic i_ftw_wr_en, // tag word write
   input wire logic [15:0] i_ftw_wr_data, // tag value
   output logic [31:0] o_gpr_rd_data, // integer read, zero-extended
   output logic [63:0] o_gpr_rd_quad, // pair read idx+1:idx
   output logic o_gpr_wr_done, // pulse: integer write took effect
   output logic [31:0] o_accum_word32, // accumulator full view
   output logic [15:0] o_accum_word16, // accumulator word view
   output logic [7:0] o_accum_upper_byte, // accumulator bits 15..8
   output logic [7:0] o_accum_lower_byte, // accumulator bits 7..0
   output logic [15:0] o_stack_top16, // stack top word view
   output logic [15:0] o_code_sel, // code segment
   output logic [15:0] o_stack_sel, // stack segment
   output logic [31:0] o_seg_base, // real-mode base address
   output logic [12:0] o_desc_index, // protected-mode descriptor index
   output logic o_desc_local, // descriptor table select bit
   output logic [1:0] o_desc_rpl, // requested privilege field
   output logic o_desc_req, // protected mode lookup needed
   output logic [31:0] o_next_fetch_ptr32, // fetch pointer
   output logic [15:0] o_next_fetch_ptr16, // low word view
   output logic [79:0] o_fp_rd_data, // float entry read
   output logic [63:0] o_mm_rd_data, // multimedia view of entry
   output logic [15:0] o_fsw, // float status word
   output logic [15:0] o_fcw, // float control word
   output logic [15:0] o_ftw // float tag word
);
   typedef struct packed {
      logic [XARF_NUM_SEG-1:0][XARF_SEG_W-1:0] seg;
      logic [31:0] ip;
      logic [XARF_NUM_FP-1:0][XARF_FP_W-1:0] fp;
      logic [15:0] fsw;
      logic [15:0] fcw;
      logic [15:0] ftw;
      logic [31:0] rd;
      logic [63:0] rdq;
      logic [31:0] base;
      logic [12:0] didx;
      logic dti;
      logic [1:0] rpl;
      logic dreq;
      logic [79:0] fprd;
      logic [63:0] mmrd;
   } xarf_state_t;

   xarf_state_t st_r;
   xarf_state_t st_nxt;
   logic [XARF_NUM_GPR-1:0][XARF_GPR_W-1:0] gpr;
   logic [15:0] sel;

   xarf_gpr_if gif ();

   xarf_gpr_bank u_gpr (
      .i_clock(i_clock),
      .i_arst_n(i_arst_n),
      .bus(gif.owner)
   );

   // single write port: a pair write stores only the low dword, pairs are read-only
   assign gif.wr_en = i_gpr_wr_en;
   assign gif.wr_idx = i_gpr_wr_idx;
   assign gif.wr_data = i_gpr_wr_data;
   assign gif.wr_size = i_gpr_wr_quad ? XARF_SZ_DWORD : i_gpr_wr_size; // [RULE6]
   assign gpr = gif.regs_flat;
   assign sel = st_r.seg[i_seg_rd_idx];

   always_comb begin
      st_nxt = st_r;
      // read paths are registered so outputs stay flop-driven
      st_nxt.rd = xarf_view(gpr[i_gpr_rd_idx], i_gpr_rd_size); // [RULE2] [RULE3] [RULE5]
      st_nxt.rdq = {gpr[3'(i_gpr_rd_idx + 3'h1)], gpr[i_gpr_rd_idx]}; // [RULE6]
      if (i_seg_wr_en && i_seg_wr_idx < 3'(XARF_NUM_SEG)) begin
         st_nxt.seg[i_seg_wr_idx] = i_seg_wr_data; // [RULE7] [RULE8]
      end
      st_nxt.base = 32'({sel, XARF_REAL_SHIFT'(0)}); // [RULE9]
      st_nxt.didx = sel[15:XARF_SEL_IDX_LSB]; // [RULE10]
      st_nxt.dti = sel[2];
      st_nxt.rpl = sel[1:0];
      st_nxt.dreq = i_prot_mode; // [RULE10]
      // no direct write path: only steps and control transfers move it
      unique case (i_ip_op)
         XARF_IP_STEP: begin
            st_nxt.ip = i_op32 ? st_r.ip + i_ip_value
               : {16'h0, 16'(st_r.ip[15:0] + i_ip_value[15:0])}; // [RULE11]
         end
         XARF_IP_XFER: begin
            st_nxt.ip = i_op32 ? i_ip_value : {16'h0, i_ip_value[15:0]}; // [RULE12]
         end
         default: begin
            st_nxt.ip = st_r.ip;
         end
      endcase
      unique case (i_fp_wr)
         XARF_FPW_FULL: st_nxt.fp[i_fp_idx] = i_fp_wr_data; // [RULE13] [RULE17]
         XARF_FPW_MM: begin
            st_nxt.fp[i_fp_idx] = {XARF_MM_EXP_FILL, i_fp_wr_data[63:0]}; // [RULE19]
         end
         default: begin
         end
      endcase
      st_nxt.fprd = st_r.fp[i_fp_idx];
      st_nxt.mmrd = st_r.fp[i_fp_idx][63:0]; // [RULE19]
      if (i_fsw_wr_en) begin
         st_nxt.fsw = i_fsw_wr_data; // [RULE14]
      end
      if (i_fcw_wr_en) begin
         st_nxt.fcw = i_fcw_wr_data; // [RULE15]
      end
      if (i_ftw_wr_en) begin
         st_nxt.ftw = i_ftw_wr_data; // [RULE16]
      end
   end

   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         st_r <= '0; // [RULE20]
         st_r.ip <= XARF_IP_RST;
         st_r.fsw <= XARF_FSW_RST;
         st_r.fcw <= XARF_FCW_RST;
         st_r.ftw <= XARF_FTW_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // views of the accumulator and stack top come from bank flops directly
   assign o_accum_word32 = gpr[XARF_GPR_ACCUM]; // [RULE1]
   assign o_accum_word16 = gpr[XARF_GPR_ACCUM][15:0]; // [RULE2]
   assign o_accum_upper_byte = gpr[XARF_GPR_ACCUM][15:8]; // [RULE3]
   assign o_accum_lower_byte = gpr[XARF_GPR_ACCUM][7:0]; // [RULE3]
   assign o_stack_top16 = gpr[XARF_GPR_STACK_TOP][15:0]; // [RULE4]
   assign o_gpr_wr_done = gif.wr_hit;
   assign o_gpr_rd_data = st_r.rd;
   assign o_gpr_rd_quad = st_r.rdq;
   assign o_code_sel = st_r.seg[XARF_SEG_CODE]; // [RULE8]
   assign o_stack_sel = st_r.seg[XARF_SEG_STACK]; // [RULE8]
   assign o_seg_base = st_r.base;
   assign o_desc_index = st_r.didx;
   assign o_desc_local = st_r.dti;
   assign o_desc_rpl = st_r.rpl;
   assign o_desc_req = st_r.dreq;
   assign o_next_fetch_ptr32 = st_r.ip;
   assign o_next_fetch_ptr16 = st_r.ip[15:0]; // [RULE11]
   assign o_fp_rd_data = st_r.fprd;
   assign o_mm_rd_data = st_r.mmrd;
   assign o_fsw = st_r.fsw;
   assign o_fcw = st_r.fcw;
   assign o_ftw = st_r.ftw;
endmodule : xarf_regfile
`default_nettype wire

// >>> verif/xarf_regfile_asserts.sv
`default_nettype none
module xarf_regfile_asserts
   import xarf_pkg::*;
(
   input wire logic i_clock, // clock
   input wire logic i_arst_n, // reset
   input wire logic i_gpr_wr_en, // gpr strobe
   input wire logic [2:0] i_gpr_wr_idx, // gpr number
   input wire xarf_size_t i_gpr_wr_size, // name width
   input wire logic [31:0] i_gpr_wr_data, // gpr data
   input wire logic i_gpr_wr_quad, // pair write
   input wire logic i_seg_wr_en, // seg strobe
   input wire logic [2:0] i_seg_wr_idx, // seg number
   input wire logic [15:0] i_seg_wr_data, // seg data
   input wire logic [2:0] i_seg_rd_idx, // base select
   input wire logic i_prot_mode, // protected
   input wire xarf_ipop_t i_ip_op, // ptr update
   input wire logic o_gpr_wr_done, // write pulse
   input wire logic [31:0] o_accum_word32, // accum
   input wire logic [15:0] o_accum_word16, // accum word
   input wire logic [7:0] o_accum_upper_byte, // accum hi
   input wire logic [7:0] o_accum_lower_byte, // accum lo
   input wire logic [15:0] o_stack_top16, // stack word
   input wire logic [15:0] o_code_sel, // code seg
   input wire logic [31:0] o_seg_base, // real base
   input wire logic o_desc_req, // lookup flag
   input wire logic [31:0] o_next_fetch_ptr32 // fetch ptr
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (!i_arst_n);
   logic acc_wr;
   // quad writes force dword, so they never count as narrow
   assign acc_wr = i_gpr_wr_en && !i_gpr_wr_quad && i_gpr_wr_idx == XARF_GPR_ACCUM;
   a_word_alias: assert property (acc_wr && i_gpr_wr_size == XARF_SZ_WORD |=>
      o_accum_word16 == $past(i_gpr_wr_data[15:0])) else $error("word write lost");
   a_high_byte: assert property (acc_wr && i_gpr_wr_size == XARF_SZ_BYTE_HI |=>
      o_accum_upper_byte == $past(i_gpr_wr_data[7:0]) && $stable(o_accum_lower_byte)
      && $stable(o_accum_word32[31:16])) else $error("high byte write wrong");
   a_index_nobyte: assert property (i_gpr_wr_en && !i_gpr_wr_quad && i_gpr_wr_idx[2] &&
      !i_gpr_wr_size[1] |=> !o_gpr_wr_done && $stable(o_stack_top16))
      else $error("index register took a byte");
   a_write_done: assert property (i_gpr_wr_en && (i_gpr_wr_quad || !i_gpr_wr_idx[2] ||
      i_gpr_wr_size[1]) |=> o_gpr_wr_done) else $error("no done pulse");
   a_code_seg: assert property (i_seg_wr_en && i_seg_wr_idx == XARF_SEG_CODE |=>
      o_code_sel == $past(i_seg_wr_data)) else $error("code segment not written");
   a_real_base: assert property (i_seg_rd_idx == XARF_SEG_CODE |=>
      o_seg_base == {12'h0, $past(o_code_sel), 4'h0}) else $error("code base wrong");
   a_lookup_flag: assert property (1'b1 |=> o_desc_req == $past(i_prot_mode))
      else $error("lookup flag wrong");
   a_fetch_hold: assert property (i_ip_op == XARF_IP_HOLD |=>
      $stable(o_next_fetch_ptr32)) else $error("fetch pointer moved");
   c_narrow_burst: cover property (acc_wr ##1 acc_wr ##1 acc_wr);
   c_xfer_step: cover property (i_ip_op == XARF_IP_XFER ##1 i_ip_op == XARF_IP_STEP);
   c_prot_code: cover property (i_prot_mode && i_seg_rd_idx == XARF_SEG_CODE);
endmodule // xarf_regfile_asserts
bind xarf_regfile xarf_regfile_asserts i_xarf_regfile_asserts (.*);
`default_nettype wire

// >>> verif/xarf_pipe_model.sv
`default_nettype none
package xarf_tb_pkg;
   import xarf_pkg::*;
   typedef struct packed {
      logic gpr_we, gpr_quad, seg_we, prot, op32, fsw_we, fcw_we, ftw_we;
      logic [2:0] gpr_widx, gpr_ridx, seg_widx, seg_ridx, fp_idx;
      xarf_size_t gpr_wsz, gpr_rsz;
      xarf_ipop_t ip_op;
      xarf_fpw_t fp_wr;
      logic [31:0] gpr_wd, gpr_wd_hi, ip_val;
      logic [15:0] seg_wd, fsw_wd, fcw_wd, ftw_wd;
      logic [79:0] fp_wd;
   } xarf_tb_req_t;
endpackage : xarf_tb_pkg

module xarf_pipe_model
   import xarf_pkg::*, xarf_tb_pkg::*;
(
   input wire logic i_clock, // core clock
   output var xarf_tb_req_t o_req // request lines
);
   timeunit 1ns;
   timeprecision 100ps;
   xarf_tb_req_t q;
   initial begin
      o_req = '0;
      o_req.fp_wr = XARF_FPW_NONE;
   end
   // whole images only; reserved bits go out as the caller built them
   task automatic send(input xarf_tb_req_t r);
      @(negedge i_clock);
      o_req = r;
   endtask
   // drop strobes, keep levels; n > 1 models a slow pipeline
   task automatic idle(input int n);
      @(negedge i_clock);
      q = o_req;
      {q.gpr_we, q.seg_we, q.fsw_we, q.fcw_we, q.ftw_we} = 5'h0;
      q.ip_op = XARF_IP_HOLD;
      q.fp_wr = XARF_FPW_NONE;
      o_req = q;
      repeat (n - 1) @(negedge i_clock);
   endtask
endmodule // xarf_pipe_model
`default_nettype wire

// >>> verif/xarf_regfile_bench.sv
`default_nettype none
module xarf_regfile_bench
   import xarf_pkg::*, xarf_tb_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic i_clock = 1'b0;
   logic i_arst_n = 1'b0;
   xarf_tb_req_t req;
   xarf_tb_req_t r;
   logic o_gpr_wr_done, o_desc_local, o_desc_req;
   logic [1:0] o_desc_rpl;
   logic [7:0] o_accum_upper_byte, o_accum_lower_byte;
   logic [12:0] o_desc_index;
   logic [15:0] o_accum_word16, o_stack_top16, o_code_sel, o_stack_sel, o_next_fetch_ptr16;
   logic [15:0] o_fsw, o_fcw, o_ftw;
   logic [31:0] o_gpr_rd_data, o_accum_word32, o_seg_base, o_next_fetch_ptr32;
   logic [63:0] o_gpr_rd_quad, o_mm_rd_data;
   logic [79:0] o_fp_rd_data;
   int mismatches = 0;
   int tests_run = 0;
   xarf_pipe_model i_xarf_pipe_model (.i_clock(i_clock), .o_req(req));
   xarf_regfile i_xarf_regfile (
      .i_gpr_wr_en(req.gpr_we), .i_gpr_wr_idx(req.gpr_widx), .i_gpr_wr_size(req.gpr_wsz),
      .i_gpr_wr_data(req.gpr_wd), .i_gpr_wr_quad(req.gpr_quad),
      .i_gpr_wr_data_hi(req.gpr_wd_hi),
      .i_gpr_rd_idx(req.gpr_ridx), .i_gpr_rd_size(req.gpr_rsz), .i_seg_wr_en(req.seg_we),
      .i_seg_wr_idx(req.seg_widx), .i_seg_wr_data(req.seg_wd), .i_seg_rd_idx(req.seg_ridx),
      .i_prot_mode(req.prot), .i_op32(req.op32), .i_ip_op(req.ip_op), .i_ip_value(req.ip_val),
      .i_fp_idx(req.fp_idx), .i_fp_wr(req.fp_wr), .i_fp_wr_data(req.fp_wd),
      .i_fsw_wr_en(req.fsw_we), .i_fsw_wr_data(req.fsw_wd), .i_fcw_wr_en(req.fcw_we),
      .i_fcw_wr_data(req.fcw_wd), .i_ftw_wr_en(req.ftw_we), .i_ftw_wr_data(req.ftw_wd), .*);
   always #4 i_clock = ~i_clock;
   task automatic chk(input string nm, input logic [79:0] exp, input logic [79:0] got);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic gw(input logic [2:0] idx, input xarf_size_t sz, input logic [31:0] d,
                     input logic q);
      r = req;
      r.gpr_we = 1'b1;
      r.gpr_quad = q;
      r.gpr_widx = idx;
      r.gpr_wsz = sz;
      r.gpr_wd = d;
      r.gpr_wd_hi = ~d;
      i_xarf_pipe_model.send(r);
   endtask
   task automatic t_gpr;
      for (int i = 0; i < 8; i++)
         gw(i[2:0], XARF_SZ_DWORD, 32'(i) * 32'h1111_1111 + 32'h0f0e_0d0c, 1'b0);
      gw(XARF_GPR_ACCUM, XARF_SZ_WORD, 32'hffff_aabb, 1'b0);
      gw(XARF_GPR_ACCUM, XARF_SZ_BYTE_HI, 32'hffff_ffcc, 1'b0);
      gw(XARF_GPR_ACCUM, XARF_SZ_BYTE_LO, 32'hffff_ffdd, 1'b0);
      chk("done", 1'b1, o_gpr_wr_done);
      gw(XARF_GPR_STACK_TOP, XARF_SZ_BYTE_HI, 32'h0000_0099, 1'b0);
      i_xarf_pipe_model.idle(1);
      chk("refused", 1'b0, o_gpr_wr_done);
      chk("stack16", 16'h5150, o_stack_top16);
      chk("accum32", 32'h0f0e_ccdd, o_accum_word32);
      chk("accum", 32'hccdd_ccdd, {o_accum_word16, o_accum_upper_byte, o_accum_lower_byte});
      gw(XARF_GPR_FRAME_BASE, XARF_SZ_BYTE_LO, 32'h0000_0077, 1'b0);
      i_xarf_pipe_model.idle(1);
      chk("refused lo", 1'b0, o_gpr_wr_done);
      gw(XARF_GPR_SOURCE_INDEX, XARF_SZ_BYTE_LO, 32'hdead_beef, 1'b1);
      r.gpr_we = 1'b0;
      r.gpr_ridx = XARF_GPR_SOURCE_INDEX;
      r.gpr_rsz = XARF_SZ_DWORD;
      i_xarf_pipe_model.send(r);
      i_xarf_pipe_model.idle(1);
      chk("quad", 64'h8685_8483_dead_beef, o_gpr_rd_quad);
      r.gpr_ridx = XARF_GPR_ACCUM;
      r.gpr_rsz = XARF_SZ_BYTE_HI;
      i_xarf_pipe_model.send(r);
      i_xarf_pipe_model.idle(1);
      chk("read byte", 32'h0000_00cc, o_gpr_rd_data);
   endtask
   task automatic t_seg;
      logic [15:0] v;
      for (int i = 0; i < 8; i++) begin
         r = req;
         r.seg_we = 1'b1;
         r.seg_widx = i[2:0];
         r.seg_wd = 16'h1230 + 16'(i);
         i_xarf_pipe_model.send(r);
      end
      i_xarf_pipe_model.idle(1);
      chk("code stack", 32'h1231_1232, {o_code_sel, o_stack_sel});
      for (int i = 0; i < 6; i++) begin
         v = 16'h1230 + 16'(i);
         r = req;
         r.seg_ridx = i[2:0];
         r.prot = i[0];
         i_xarf_pipe_model.send(r);
         i_xarf_pipe_model.idle(1);
         chk("base", {v, 4'h0}, o_seg_base);
         chk("desc", v, {o_desc_index, o_desc_local, o_desc_rpl});
         chk("lookup", r.prot, o_desc_req);
      end
   endtask
   task automatic t_ip;
      r = req;
      r.op32 = 1'b1;
      r.ip_op = XARF_IP_XFER;
      r.ip_val = 32'h0001_fff0;
      i_xarf_pipe_model.send(r);
      r.ip_op = XARF_IP_STEP;
      r.ip_val = 32'h0000_0010;
      i_xarf_pipe_model.send(r);
      i_xarf_pipe_model.idle(4);
      chk("fetch32", 32'h0002_0000, o_next_fetch_ptr32);
      r.ip_op = XARF_IP_XFER;
      r.ip_val = 32'h0000_fff8;
      i_xarf_pipe_model.send(r);
      r.op32 = 1'b0;
      r.ip_op = XARF_IP_STEP;
      r.ip_val = 32'h0000_0010;
      i_xarf_pipe_model.send(r);
      i_xarf_pipe_model.idle(1);
      chk("fetch16", 48'h0000_0008_0008, {o_next_fetch_ptr32, o_next_fetch_ptr16});
   endtask
   task automatic t_fp;
      r = req;
      r.fp_idx = 3'h3;
      r.fp_wr = XARF_FPW_FULL;
      r.fp_wd = 80'h4000_c90f_daa2_2168_c235;
      i_xarf_pipe_model.send(r);
      r.fp_idx = 3'h5;
      r.fp_wr = XARF_FPW_MM;
      r.fp_wd = 80'h1234_0102_0304_0506_0708;
      i_xarf_pipe_model.send(r);
      r.fp_idx = 3'h3;
      r.fp_wr = XARF_FPW_NONE;
      {r.fsw_we, r.fcw_we, r.ftw_we} = 3'h7;
      {r.fsw_wd, r.fcw_wd, r.ftw_wd} = 48'h3800_037f_5a5a;
      i_xarf_pipe_model.send(r);
      i_xarf_pipe_model.idle(1);
      chk("entry", 80'h4000_c90f_daa2_2168_c235, o_fp_rd_data);
      chk("words", 48'h3800_037f_5a5a, {o_fsw, o_fcw, o_ftw});
      r = req;
      r.fp_idx = 3'h5;
      i_xarf_pipe_model.send(r);
      i_xarf_pipe_model.idle(1);
      chk("shared", 80'hffff_0102_0304_0506_0708, o_fp_rd_data);
      chk("mm", 64'h0102_0304_0506_0708, o_mm_rd_data);
   endtask
   task automatic print_verdict;
      if (mismatches == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge i_clock);
      @(negedge i_clock);
      i_arst_n = 1'b1;
      chk("reset", 80'h0, {o_accum_word32, o_code_sel, o_next_fetch_ptr32});
      chk("reset fp", 80'h0, o_fp_rd_data | {o_fsw, o_fcw, o_ftw});
      t_gpr();
      t_seg();
      t_ip();
      t_fp();
      print_verdict();
   end
   // the tests need well under 100 cycles
   initial begin
      #20000;
      mismatches++;
      print_verdict();
   end
endmodule // xarf_regfile_bench
`default_nettype wire
